// ### hdl/adp_i2c_data_port.sv
// Purpose: Two-wire slave port, result/setup registers, conversion sequencer
// Assumes: clk_link_in oversamples the bus; front end gives code at conversion end
// Notes: Setup bytes cross as quasi-static words behind a toggle; result word is sampled only while not busy
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE_01 - Ack pulls data low, nack releases
// RULE_02 - Data line changes only while clock low
// RULE_03 - Master sends address then direction bit
// RULE_04 - Selected only on own strapped address
// RULE_05 - Nack address while converting, ack after
// RULE_06 - Hold 32-bit result, 16-bit setup register
// RULE_07 - Sleep after each conversion until restart
// RULE_08 - Read ack then transmit up to four bytes
// RULE_09 - Four-byte read restarts conversion, nack meanwhile
// RULE_10 - Result shifted MSB first on falling edges
// RULE_11 - Sign bit high for zero or positive
// RULE_12 - Top two bits flag over and under range
// RULE_13 - Two's complement result plus six sub bits
// RULE_14 - Clamp over and under range codes
// RULE_15 - Double-speed underrange reads 3FFFF upper bits
// RULE_16 - Zero result sign may be either value
// RULE_17 - Setup written as two eight-bit bytes
// RULE_18 - Reset defaults then automatic first conversion
// RULE_19 - Accept up to two setup bytes
// RULE_20 - Master uses prefixes 000, 100, 101
// RULE_21 - Prefix 000 or 100 keeps channel
// RULE_22 - Prefix 101 loads five channel bits
// RULE_23 - Single-ended bit picks differential or common
// RULE_24 - Channel bits decode pair and polarity
// RULE_25 - Load-enable bit gates converter settings load
// RULE_26 - Temperature mode forces single speed
// RULE_27 - Partial read keeps result, no restart
module adp_i2c_data_port
  import adp_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_1X_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic clk_link_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic [ADDR_W-1:0] addr_strap_in,
  input wire logic [CODE_W-1:0] adc_code_in,
  input wire logic adc_over_range_in,
  input wire logic adc_under_range_in,
  output logic conv_start_out,
  output logic conv_busy_out,
  output adp_mux_t mux_out,
  output adp_conv_cfg_t conv_cfg_out
);

  localparam int CNT_W = $clog2(CONV_CYCLES + 1);
  localparam logic [CNT_W-1:0] LEN_1X = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] LEN_2X = CNT_W'(CONV_CYCLES / 2 - 1);

  // Link domain: reset and pin synchronisers
  logic [1:0] lrst_s;
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [ADDR_W-1:0] strap_s0;
  logic [ADDR_W-1:0] strap_s1;
  logic [1:0] busy_s;
  logic lrst;

  // Sys domain crossing flops
  logic [2:0] rd_s;
  logic [2:0] cf_s;

  // Link state
  adp_link_state_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic rw_q, rw_d;
  logic [1:0] byte_q, byte_d;
  logic [1:0] wr_n_q, wr_n_d;
  logic [7:0] w1_q, w1_d;
  logic [7:0] w2_q, w2_d;
  logic [1:0] cfg_n_q, cfg_n_d;
  logic sda_low_q, sda_low_d;
  logic [RESULT_W-1:0] tx_q, tx_d;
  logic rd_tog_q, rd_tog_d;
  logic cfg_tog_q, cfg_tog_d;
  logic [ADDR_W-1:0] own_q, own_d;
  logic rise, fall, start_c, stop_c;

  // Sys state
  // RULE_06 result and setup registers
  adp_conv_state_t cst_q, cst_d;
  logic [CNT_W-1:0] ccnt_q, ccnt_d;
  logic [RESULT_W-1:0] result_q, result_d;
  adp_chan_t chan_q, chan_d, achan_q, achan_d;
  adp_conv_cfg_t cfg_q, cfg_d, acfg_q, acfg_d;
  logic start_q, start_d;
  logic rd_ev, cf_ev;

  assign lrst = lrst_s[1];

  always_ff @(posedge clk_link_in) begin
    lrst_s <= {lrst_s[0], reset_in};
    scl_s <= {scl_s[1:0], scl_in};
    sda_s <= {sda_s[1:0], sda_in};
    strap_s0 <= addr_strap_in;
    strap_s1 <= strap_s0;
    busy_s <= {busy_s[0], conv_busy_out};
  end

  assign rise = scl_s[1] & ~scl_s[2];
  assign fall = ~scl_s[1] & scl_s[2];
  assign start_c = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  assign stop_c = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    rw_d = rw_q;
    byte_d = byte_q;
    wr_n_d = wr_n_q;
    w1_d = w1_q;
    w2_d = w2_q;
    cfg_n_d = cfg_n_q;
    sda_low_d = sda_low_q;
    tx_d = tx_q;
    rd_tog_d = rd_tog_q;
    cfg_tog_d = cfg_tog_q;
    own_d = own_q;
    if (lrst) begin
      // Strap is caught while reset is held
      own_d = strap_s1;
      st_d = LK_IDLE;
      cnt_d = 3'h0;
      sh_d = 8'h00;
      rw_d = 1'b0;
      byte_d = 2'h0;
      wr_n_d = 2'h0;
      w1_d = 8'h00;
      w2_d = 8'h00;
      cfg_n_d = 2'h0;
      sda_low_d = 1'b0;
      tx_d = RESULT_RESET;
      rd_tog_d = 1'b0;
      cfg_tog_d = 1'b0;
    end else if (start_c || stop_c) begin
      st_d = start_c ? LK_ADDR : LK_IDLE;
      cnt_d = 3'h0;
      sda_low_d = 1'b0;
      // Setup bytes cross when the transaction closes; outputs change at the next conversion start
      if (wr_n_q != 2'h0) begin
        cfg_tog_d = ~cfg_tog_q;
        cfg_n_d = wr_n_q;
        wr_n_d = 2'h0;
      end
    end else begin
      unique case (st_q)
        LK_IDLE: begin
        end
        LK_ADDR: begin
          // RULE_03 address and direction
          if (rise) begin
            sh_d = {sh_q[6:0], sda_s[1]};
            if (cnt_q == LAST_BIT) begin
              st_d = LK_ADDR_END;
            end else begin
              cnt_d = cnt_q + 3'h1;
            end
          end
        end
        LK_ADDR_END: begin
          if (fall) begin
            cnt_d = 3'h0;
            // RULE_04 own address match
            // RULE_05 nack while busy
            if (sh_q[7:1] == own_q && !busy_s[1]) begin
              rw_d = sh_q[0];
              // RULE_01 ack pulls low
              sda_low_d = 1'b1;
              st_d = LK_ACK_OUT;
              byte_d = 2'h0;
              tx_d = result_q;
            end else begin
              st_d = LK_IDLE;
            end
          end
        end
        LK_ACK_OUT: begin
          if (fall) begin
            // RULE_08 become transmitter
            if (rw_q) begin
              sda_low_d = ~tx_q[RESULT_W-1];
              st_d = LK_TX;
            end else begin
              sda_low_d = 1'b0;
              st_d = LK_RX;
            end
          end
        end
        LK_RX: begin
          if (rise) begin
            sh_d = {sh_q[6:0], sda_s[1]};
            if (cnt_q == LAST_BIT) begin
              st_d = LK_RX_END;
            end else begin
              cnt_d = cnt_q + 3'h1;
            end
          end
        end
        LK_RX_END: begin
          if (fall) begin
            cnt_d = 3'h0;
            // RULE_19 two bytes at most
            if (wr_n_q != MAX_WR_BYTES) begin
              wr_n_d = wr_n_q + 2'h1;
              if (wr_n_q == 2'h0) begin
                w1_d = sh_q;
              end else begin
                w2_d = sh_q;
              end
              sda_low_d = 1'b1;
              st_d = LK_ACK_OUT;
            end else begin
              st_d = LK_IDLE;
            end
          end
        end
        LK_TX: begin
          if (rise) begin
            if (cnt_q == LAST_BIT) begin
              st_d = LK_TX_END;
            end else begin
              cnt_d = cnt_q + 3'h1;
            end
          end else if (fall) begin
            // RULE_02 change only after fall
            // RULE_10 MSB first on fall
            tx_d = {tx_q[RESULT_W-2:0], 1'b0};
            sda_low_d = ~tx_q[RESULT_W-2];
          end
        end
        LK_TX_END: begin
          if (fall) begin
            sda_low_d = 1'b0;
            tx_d = {tx_q[RESULT_W-2:0], 1'b0};
            cnt_d = 3'h0;
            // RULE_09 full read restarts
            // RULE_27 partial read no restart
            if (byte_q == LAST_READ_BYTE) begin
              rd_tog_d = ~rd_tog_q;
              st_d = LK_IDLE;
            end else begin
              byte_d = byte_q + 2'h1;
              st_d = LK_MACK;
            end
          end
        end
        LK_MACK: begin
          if (rise) begin
            st_d = sda_s[1] ? LK_IDLE : LK_TX_NEXT;
          end
        end
        LK_TX_NEXT: begin
          if (fall) begin
            sda_low_d = ~tx_q[RESULT_W-1];
            st_d = LK_TX;
          end
        end
        default: begin
          st_d = LK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_link_in) begin
    st_q <= st_d;
    cnt_q <= cnt_d;
    sh_q <= sh_d;
    rw_q <= rw_d;
    byte_q <= byte_d;
    wr_n_q <= wr_n_d;
    w1_q <= w1_d;
    w2_q <= w2_d;
    cfg_n_q <= cfg_n_d;
    sda_low_q <= sda_low_d;
    tx_q <= tx_d;
    rd_tog_q <= rd_tog_d;
    cfg_tog_q <= cfg_tog_d;
    own_q <= own_d;
  end

  // Open-drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n_out = ~sda_low_q;

  // Sys domain
  always_ff @(posedge clk_sys_in) begin
    rd_s <= {rd_s[1:0], rd_tog_q};
    cf_s <= {cf_s[1:0], cfg_tog_q};
  end

  assign rd_ev = rd_s[1] ^ rd_s[2];
  assign cf_ev = cf_s[1] ^ cf_s[2];

  // RULE_11 sign bit from code
  // RULE_12 range flags in top bits
  // RULE_13 two's complement with sub bits
  // RULE_14 clamped range codes
  // RULE_15 underrange upper bits 3FFFF
  // RULE_16 zero always reports sign high
  function automatic logic [RESULT_W-1:0] fmt_result(
    input logic [CODE_W-1:0] code,
    input logic over,
    input logic under
  );
    logic [RESULT_W-1:0] r;
    r = {~code[CODE_W-1], code};
    if (over) begin
      r = RESULT_OVER;
    end else if (under) begin
      r = RESULT_UNDER;
    end
    return r;
  endfunction : fmt_result

  always_comb begin
    cst_d = cst_q;
    ccnt_d = ccnt_q;
    result_d = result_q;
    chan_d = chan_q;
    cfg_d = cfg_q;
    achan_d = achan_q;
    acfg_d = acfg_q;
    start_d = 1'b0;
    if (reset_in) begin
      // RULE_18 defaults and first conversion
      cst_d = CV_CONVERT;
      ccnt_d = LEN_1X;
      result_d = RESULT_RESET;
      chan_d = CHAN_DEFAULT;
      cfg_d = CFG_DEFAULT;
      achan_d = CHAN_DEFAULT;
      acfg_d = CFG_DEFAULT;
      start_d = 1'b1;
    end else begin
      if (cf_ev) begin
        // RULE_17 two setup bytes
        // RULE_21 other prefixes keep channel
        // RULE_22 prefix loads channel
        if (cfg_n_q != 2'h0 && w1_q[PREFIX_HI:PREFIX_LO] == PREFIX_LOAD) begin
          chan_d = w1_q[CHAN_HI:0];
        end
        // RULE_25 load-enable gates settings
        if (cfg_n_q == MAX_WR_BYTES && w2_q[LOAD_EN_BIT]) begin
          cfg_d = {w2_q[TEMP_BIT], w2_q[REJ_A_BIT], w2_q[REJ_B_BIT], w2_q[RATE_BIT]};
        end
      end
      unique case (cst_q)
        CV_CONVERT: begin
          if (ccnt_q == '0) begin
            result_d = fmt_result(adc_code_in, adc_over_range_in, adc_under_range_in);
            // RULE_07 sleep after conversion
            cst_d = CV_SLEEP;
          end else begin
            ccnt_d = ccnt_q - CNT_W'(1);
          end
        end
        CV_SLEEP: begin
          // RULE_09 restart after full read
          if (rd_ev) begin
            cst_d = CV_CONVERT;
            achan_d = chan_d;
            acfg_d = cfg_d;
            start_d = 1'b1;
            // RULE_26 temperature forces single speed
            ccnt_d = (cfg_d.double_rate_select && !cfg_d.temp_sensor_select) ? LEN_2X : LEN_1X;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    cst_q <= cst_d;
    ccnt_q <= ccnt_d;
    result_q <= result_d;
    chan_q <= chan_d;
    cfg_q <= cfg_d;
    achan_q <= achan_d;
    acfg_q <= acfg_d;
    start_q <= start_d;
  end

  assign conv_busy_out = (cst_q == CV_CONVERT);
  assign conv_start_out = start_q;

  always_comb begin
    logic [3:0] base;
    base = {achan_q.pair_index_bit2, achan_q.pair_index_bit1, achan_q.pair_index_bit0, 1'b0};
    conv_cfg_out = acfg_q;
    conv_cfg_out.double_rate_select = acfg_q.double_rate_select & ~acfg_q.temp_sensor_select;
    // RULE_23 single-ended uses common
    // RULE_24 pair and polarity decode
    mux_out.pos = base | {3'h0, achan_q.polarity_swap};
    mux_out.neg = base | {3'h0, ~achan_q.polarity_swap};
    mux_out.neg_is_common = achan_q.single_ended_select;
  end

  // Link-side checks
  ack_drive_a: assert property (@(posedge clk_link_in) disable iff (lrst) // RULE_01
    st_q == LK_ACK_OUT |-> !sda_oe_n_out)
    else $error("ack slot not driven low");

  quiet_change_a: assert property (@(posedge clk_link_in) disable iff (lrst) // RULE_02
    $changed(sda_oe_n_out) |-> !scl_s[2])
    else $error("data changed while clock high");

  busy_nack_a: assert property (@(posedge clk_link_in) disable iff (lrst) // RULE_05
    (st_q == LK_ADDR_END && fall && !start_c && !stop_c && busy_s[1])
      |=> st_q == LK_IDLE && sda_oe_n_out)
    else $error("address acked while busy");

  addr_match_a: assert property (@(posedge clk_link_in) disable iff (lrst) // RULE_04
    (st_q == LK_ADDR_END && fall && !start_c && !stop_c && sh_q[7:1] != own_q)
      |=> st_q == LK_IDLE)
    else $error("foreign address acked");

  // Sys-side checks
  sleep_entry_a: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE_07
    (cst_q == CV_CONVERT && ccnt_q == '0) |=> cst_q == CV_SLEEP ##1 cst_q == CV_SLEEP || rd_ev)
    else $error("no sleep after conversion");

  read_restart_a: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE_09
    (cst_q == CV_SLEEP && rd_ev) |=> conv_busy_out && conv_start_out)
    else $error("full read did not restart");

  over_code_a: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE_14
    (cst_q == CV_CONVERT && ccnt_q == '0 && adc_over_range_in) |=> result_q == RESULT_OVER)
    else $error("overrange not clamped");

  sign_bit_a: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE_11
    (cst_q == CV_CONVERT && ccnt_q == '0 && !adc_over_range_in && !adc_under_range_in)
      |=> result_q[31] == !$past(adc_code_in[CODE_W-1]))
    else $error("sign bit wrong");

  chan_keep_a: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE_21
    (cf_ev && w1_q[PREFIX_HI:PREFIX_LO] != PREFIX_LOAD) |=> $stable(chan_q))
    else $error("channel changed without load prefix");

  temp_rate_a: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RULE_26
    acfg_q.temp_sensor_select |-> !conv_cfg_out.double_rate_select)
    else $error("double rate with temperature");

  read_done_c: cover property (@(posedge clk_sys_in) disable iff (reset_in)
    cst_q == CV_SLEEP && rd_ev);
  setup_load_c: cover property (@(posedge clk_sys_in) disable iff (reset_in)
    cf_ev && cfg_n_q == MAX_WR_BYTES && w2_q[LOAD_EN_BIT]);
  busy_nack_c: cover property (@(posedge clk_link_in) disable iff (lrst)
    st_q == LK_ADDR_END && fall && busy_s[1]);
  tx_byte_c: cover property (@(posedge clk_link_in) disable iff (lrst)
    st_q == LK_MACK && rise && !sda_s[1]);

endmodule : adp_i2c_data_port

`default_nettype wire

// ### hdl/adp_pkg.sv
// Purpose: Shared constants and types for the two-wire converter data port
// Assumes: 10 MHz system clock, serial engine on its own link clock
// Notes: Reject-mode encodings are passed through untouched
package adp_pkg;

  localparam int CLK_SYS_MHZ = 10;
  // Single-speed conversion time, microseconds; plain default
  localparam int CONV_1X_TIME_US = 1000;
  localparam int CONV_1X_CYCLES = CONV_1X_TIME_US * CLK_SYS_MHZ;

  localparam int RESULT_W = 32;
  localparam int SETUP_W = 16;
  localparam int CODE_W = 31;
  localparam int ADDR_W = 7;

  localparam logic [1:0] LAST_READ_BYTE = 2'h3;
  localparam logic [1:0] MAX_WR_BYTES = 2'h2;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // First setup byte
  localparam int PREFIX_HI = 7;
  localparam int PREFIX_LO = 5;
  localparam int CHAN_HI = 4;
  localparam logic [2:0] PREFIX_KEEP_A = 3'h0;
  localparam logic [2:0] PREFIX_KEEP_B = 3'h4;
  localparam logic [2:0] PREFIX_LOAD = 3'h5;

  // Second setup byte
  localparam int LOAD_EN_BIT = 7;
  localparam int TEMP_BIT = 6;
  localparam int REJ_A_BIT = 5;
  localparam int REJ_B_BIT = 4;
  localparam int RATE_BIT = 3;

  localparam logic [31:0] RESULT_OVER = 32'hC0000000;
  localparam logic [31:0] RESULT_UNDER = 32'h3FFFFFFF;
  localparam logic [31:0] RESULT_RESET = 32'h00000000;

  typedef struct packed {
    logic single_ended_select;
    logic polarity_swap;
    logic pair_index_bit2;
    logic pair_index_bit1;
    logic pair_index_bit0;
  } adp_chan_t;

  typedef struct packed {
    logic temp_sensor_select;
    logic reject_sel_a;
    logic reject_sel_b;
    logic double_rate_select;
  } adp_conv_cfg_t;

  typedef struct packed {
    logic [3:0] pos;
    logic [3:0] neg;
    logic neg_is_common;
  } adp_mux_t;

  // Channel 0 positive, channel 1 negative
  localparam adp_chan_t CHAN_DEFAULT = 5'h00;
  // Combined rejection, single speed, external input
  localparam adp_conv_cfg_t CFG_DEFAULT = 4'h0;

  typedef enum logic [3:0] {
    LK_IDLE = 4'h0,
    LK_ADDR = 4'h1,
    LK_ADDR_END = 4'h2,
    LK_ACK_OUT = 4'h3,
    LK_RX = 4'h4,
    LK_RX_END = 4'h5,
    LK_TX = 4'h6,
    LK_TX_END = 4'h7,
    LK_MACK = 4'h8,
    LK_TX_NEXT = 4'h9
  } adp_link_state_t;

  typedef enum logic {
    CV_CONVERT = 1'b0,
    CV_SLEEP = 1'b1
  } adp_conv_state_t;

endpackage : adp_pkg

// ### sim/adp_bus_master.sv
// Purpose: Behavioural two-wire bus master facing the converter port
// Assumes: Open-drain data line with pull-up, clock idles high between frames
// Notes: Each received ack bit or byte is reported on got_stb_out for one cycle
`timescale 1ns/1ps
`default_nettype none
module adp_bus_master (
  input wire logic clk_link_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_n_out,
  output logic got_stb_out,
  output logic [7:0] got_val_out
);
  initial begin
    scl_out = 1'b1;
    sda_oe_n_out = 1'b1;
    got_stb_out = 1'b0;
    got_val_out = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_link_in);
    #1;
  endtask : tick
  task automatic report(input logic [7:0] v);
    got_val_out = v;
    got_stb_out = 1'b1;
    tick(1);
    got_stb_out = 1'b0;
  endtask : report
  task automatic start();
    sda_oe_n_out = 1'b1;
    scl_out = 1'b1;
    tick(4);
    sda_oe_n_out = 1'b0;
    tick(4);
    scl_out = 1'b0;
    tick(2);
  endtask : start
  task automatic stop();
    sda_oe_n_out = 1'b0;
    tick(4);
    scl_out = 1'b1;
    tick(4);
    sda_oe_n_out = 1'b1;
    tick(4);
  endtask : stop
  task automatic bit_io(input logic b, output logic s);
    sda_oe_n_out = b;
    tick(6);
    scl_out = 1'b1;
    tick(3);
    s = sda_in;
    tick(3);
    scl_out = 1'b0;
    tick(2);
  endtask : bit_io
  task automatic write_byte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    report({7'h00, s});
  endtask : write_byte
  task automatic read_byte(input logic last);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
    report(d);
  endtask : read_byte
endmodule : adp_bus_master
`default_nettype wire

// ### sim/adp_i2c_data_port_test.sv
// Purpose: Self-checking bench for the converter data port
// Assumes: Short conversion parameter, link clock unrelated to system clock
// Notes: Bus results are queued by the driver and compared by a monitor
`timescale 1ns/1ps
`default_nettype none
module adp_i2c_data_port_test;
  import adp_pkg::*;
  localparam logic [6:0] STRAP = 7'h14;
  logic [6:0] strap = STRAP;
  logic clk_sys_in = 1'b0;
  logic clk_link_in = 1'b0;
  logic reset_in = 1'b1;
  logic scl, sda_out, sda_oe_n, m_oe_n, got_stb, conv_start, conv_busy;
  logic [7:0] got_val;
  logic [CODE_W-1:0] adc_code = 31'h0;
  logic adc_over = 1'b0;
  logic adc_under = 1'b0;
  adp_mux_t mux;
  adp_conv_cfg_t cfg;
  logic [31:0] exp_q[$];
  logic [31:0] r1, r4;
  int n_mismatch = 0;
  int n_tests = 0;
  int seed = 43;
  wire sda_wire = (sda_oe_n ? 1'b1 : sda_out) & m_oe_n;
  initial forever #50 clk_sys_in = ~clk_sys_in;
  initial begin
    #37;
    forever #62.5 clk_link_in = ~clk_link_in;
  end
  adp_i2c_data_port #(.CONV_CYCLES(400)) u_adp_i2c_data_port (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .clk_link_in(clk_link_in),
    .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n),
    .addr_strap_in(strap), .adc_code_in(adc_code), .adc_over_range_in(adc_over),
    .adc_under_range_in(adc_under), .conv_start_out(conv_start),
    .conv_busy_out(conv_busy), .mux_out(mux), .conv_cfg_out(cfg));
  adp_bus_master u_adp_bus_master (
    .clk_link_in(clk_link_in), .sda_in(sda_wire), .scl_out(scl),
    .sda_oe_n_out(m_oe_n), .got_stb_out(got_stb), .got_val_out(got_val));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  always @(posedge clk_link_in) begin
    if (got_stb === 1'b1) begin
      if (exp_q.size() > 0) check({24'h0, got_val}, exp_q.pop_front());
      else check({24'h0, got_val}, 32'hFFFF_FFFF);
    end
  end
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic wait_busy(input logic lvl);
    int i;
    for (i = 0; i < 3000 && conv_busy !== lvl; i++) @(posedge clk_sys_in);
    if (i == 3000) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: busy wait ran out", $time);
      tally_and_finish();
    end
    u_adp_bus_master.tick(4);
  endtask : wait_busy
  task automatic set_adc(input logic [30:0] c, input logic o, input logic u);
    @(posedge clk_sys_in);
    #5;
    adc_code = c;
    adc_over = o;
    adc_under = u;
  endtask : set_adc
  task automatic addr(input logic [6:0] a, input logic rw, input logic [7:0] ack);
    exp_q.push_back({24'h0, ack});
    u_adp_bus_master.start();
    u_adp_bus_master.write_byte({a, rw});
  endtask : addr
  task automatic read_res(input int n, input logic [31:0] w);
    addr(STRAP, 1'b1, 8'h00);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({24'h0, w[31-8*i -: 8]});
      u_adp_bus_master.read_byte(i == n - 1);
    end
    u_adp_bus_master.stop();
  endtask : read_res
  task automatic write_setup(input logic [7:0] b1, input logic [7:0] b2);
    addr(STRAP, 1'b0, 8'h00);
    exp_q.push_back(32'h0);
    u_adp_bus_master.write_byte(b1);
    exp_q.push_back(32'h0);
    u_adp_bus_master.write_byte(b2);
    exp_q.push_back(32'h1);
    u_adp_bus_master.write_byte(8'h00);
    u_adp_bus_master.stop();
  endtask : write_setup
  task automatic check_mux(input logic [3:0] p, input logic [3:0] n, input logic com);
    check({28'h0, mux.pos}, {28'h0, p});
    check({31'h0, mux.neg_is_common}, {31'h0, com});
    if (!com) check({28'h0, mux.neg}, {28'h0, n});
  endtask : check_mux
  task automatic full_restart(input logic [31:0] w);
    read_res(4, w);
    wait_busy(1'b1);
    addr(STRAP, 1'b1, 8'h01);
    u_adp_bus_master.stop();
    wait_busy(1'b0);
  endtask : full_restart
  initial begin
    r1 = {~adc_code[30], adc_code};
    set_adc(31'($random(seed)), 1'b0, 1'b0);
    r1 = {~adc_code[30], adc_code};
    repeat (5) @(posedge clk_sys_in);
    check({31'h0, conv_start}, 32'h1);
    #5;
    reset_in = 1'b0;
    @(posedge clk_sys_in);
    #5;
    check({31'h0, conv_busy}, 32'h1);
    check_mux(4'h0, 4'h1, 1'b0);
    check({28'h0, cfg}, 32'h0);
    u_adp_bus_master.tick(4);
    addr(STRAP, 1'b0, 8'h01);
    u_adp_bus_master.stop();
    $display("Test busy refusal done");
    wait_busy(1'b0);
    addr(STRAP ^ 7'h01, 1'b1, 8'h01);
    u_adp_bus_master.stop();
    read_res(2, r1);
    u_adp_bus_master.tick(20);
    check({31'h0, conv_busy}, 32'h0);
    $display("Test addressing and partial read done");
    write_setup(8'hBA, 8'hE8);
    check_mux(4'h0, 4'h1, 1'b0);
    set_adc(31'h0, 1'b1, 1'b0);
    full_restart(r1);
    check_mux(4'h5, 4'h0, 1'b1);
    check({28'h0, cfg}, 32'hC);
    $display("Test single-ended setup done");
    write_setup(8'h9F, 8'h7F);
    set_adc(31'h0, 1'b0, 1'b1);
    full_restart(RESULT_OVER);
    check_mux(4'h5, 4'h0, 1'b1);
    check({28'h0, cfg}, 32'hC);
    $display("Test kept setup and over range done");
    write_setup(8'hAB, 8'hB8);
    set_adc(31'($random(seed)), 1'b0, 1'b0);
    r4 = {~adc_code[30], adc_code};
    full_restart(RESULT_UNDER);
    check_mux(4'h7, 4'h6, 1'b0);
    check({28'h0, cfg}, 32'h7);
    read_res(4, r4);
    wait_busy(1'b1);
    wait_busy(1'b0);
    u_adp_bus_master.tick(40);
    check({31'h0, conv_busy}, 32'h0);
    check(exp_q.size(), 32'h0);
    $display("Test differential and double rate done");
    tally_and_finish();
  end
endmodule : adp_i2c_data_port_test
`default_nettype wire
